//--- usb_host_port_interrupt_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "usb_hpis_cfg.svh"
module usb_host_port_interrupt_status
  import usb_hpis_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`NUM_PORTS-1:0] line_attached,
  input wire logic [`NUM_PORTS-1:0] remote_wakeup_evt,
  input wire logic [`NUM_PORTS-1:0] chirp_good_evt,
  input wire logic [`NUM_PORTS-1:0] chirp_bad_evt,
  input wire logic [`NUM_PORTS-1:0] disabled_done_evt,
  input wire logic [`NUM_PORTS-1:0] resume_done_evt,
  input wire logic [`NUM_PORTS-1:0] suspend_done_evt,
  input wire logic [`NUM_PORTS-1:0] bus_reset_done_evt,
  input wire logic [`NUM_PORTS-1:0] port_fault_evt,
  input wire logic [`NUM_PORTS-1:0] sof_evt,
  input wire logic [`NUM_PORTS-1:0] keepalive_evt,
  input wire logic [`NUM_PORTS-1:0][`UFRAME_W-1:0] microframe,
  input wire logic [`NUM_PORTS-1:0][7:0] frame_count_high,
  input wire logic [`NUM_PORTS-1:0] transfer_size_done_evt,
  input wire logic [`NUM_PORTS-1:0] transaction_count_done_evt,
  input wire logic [`NUM_PORTS-1:0] transaction_error_evt,
  input wire logic [`NUM_PORTS-1:0] condition_changed_evt,
  input wire logic [`NUM_PORTS-1:0] control_assist_done_evt,
  input wire logic [`NUM_PORTS-1:0] control_assist_stop_evt,
  input wire logic [`NUM_PORTS-1:0][`NUM_CHAN-1:0][7:0] chan_status,
  input wire logic [`NUM_PORTS-1:0][`NUM_CHAN-1:0][7:0] chan_enable,
  output logic cpu_irq_n,
  output logic [`NUM_PORTS-1:0][`SPEED_W-1:0] link_speed,
  output logic port_role_select
);

  // registered state and its next value
  status_state_t s;
  status_state_t next_s;

  // pulses and summaries from the per-port helpers
  logic [`NUM_PORTS-1:0] conn_pulse;
  logic [`NUM_PORTS-1:0] discon_pulse;
  logic [`NUM_PORTS-1:0][`NUM_CHAN-1:0] chsum;

  // bus decode and per-port working values
  logic [`IDX_W-1:0] idx;
  logic [`IDX_W-1:0] lidx;
  logic sel_port;
  logic wr_take;
  logic wr_here;
  logic host;
  logic [`NUM_PORTS-1:0] port_pend;
  logic rd_hit;
  logic [31:0] rd_data;
  logic [7:0] clr;
  logic [7:0] line_set;
  logic [7:0] done_set;
  logic [7:0] frame_set;
  logic [7:0] ch0_set;
  logic sof_set;
  logic wrap;

  // line and done status bits are visible only in host role; port 1 is host only
  function automatic logic host_ok(input logic port, input logic role);
    return port ? `ROLE_HOST : role;
  endfunction

  // write-one-to-clear with the hardware set winning over the clear
  function automatic logic [7:0] w1c(input logic [7:0] old, input logic [7:0] set, input logic [7:0] wr);
    return (old & ~wr) | set;
  endfunction

  // start-of-frame source for the link speed in use
  function automatic logic sof_hit(input logic [`SPEED_W-1:0] speed, input logic sof, input logic keep,
    input logic [`UFRAME_W-1:0] uframe);
    logic hit;
    hit = 1'b0;
    case (speed)
      `SPEED_HS:
        hit = sof && (uframe == `UFRAME_ZERO); // RQ18
      `SPEED_FS:
        hit = sof; // RQ18
      `SPEED_LS:
        hit = keep; // RQ18
      default:
        hit = 1'b0;
    endcase
    return hit;
  endfunction

  // any flag of one register that is pending and enabled
  function automatic logic cause(input logic [7:0] flags, input logic [7:0] enables);
    return |(flags & enables);
  endfunction

  // per-port line synchroniser and channel summary
  genvar g;
  generate
    for (g = 0; g < `NUM_PORTS; g++)
    begin : g_port
      line_detect u_line (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .attached(line_attached[g]),
        .attach_pulse(conn_pulse[g]),
        .detach_pulse(discon_pulse[g])
      );

      channel_summary #(
        .CHANNELS(`NUM_CHAN)
      ) u_sum (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .chan_status(chan_status[g]),
        .chan_enable(chan_enable[g]),
        .summary(chsum[g])
      );
    end
  endgenerate

  // pending enabled causes, one bit per port copy
  genvar q;
  generate
    for (q = 0; q < `NUM_PORTS; q++)
    begin : g_pend
      assign port_pend[q] = cause(8'(s.line[q]), 8'(s.line_en[q]))
        || cause(8'(s.done[q]), 8'(s.done_en[q]))
        || cause(8'(s.frame[q]), 8'(s.frame_en[q]))
        || cause(s.ch0[q], s.ch0_en[q])
        || |chsum[q]; // RQ9
    end
  endgenerate

  // address decode: the port bit selects the copy, the rest the register
  always_comb
  begin
    idx = paddr[`IDX_HI:`IDX_LO];
    sel_port = idx[`PORT_BIT]; // RQ20
    lidx = idx & ~`PORT_STRIDE; // RQ20
  end

  // read mux for the addressed port, reserved bits read as zero
  always_comb
  begin
    rd_hit = 1'b1;
    rd_data = `WORD_ZERO;
    host = host_ok(sel_port, s.role);
    // status registers first, own control registers after
    case (lidx)
      `IDX_LINE:
      begin
        if (host)
          rd_data = 32'(s.line[sel_port]); // RQ8
      end
      `IDX_DONE:
      begin
        if (host)
          rd_data = 32'(s.done[sel_port]); // RQ8
      end
      `IDX_FRAME:
        rd_data = 32'(s.frame[sel_port]);
      `IDX_CHSUM:
        rd_data = 32'(chsum[sel_port]); // RQ19
      `IDX_CH0:
        rd_data = 32'(s.ch0[sel_port] & `CH0_MASK); // RQ23
      `IDX_SPEED:
        rd_data = 32'(s.speed[sel_port]);
      `IDX_ROLE:
        rd_data = 32'(host_ok(sel_port, s.role));
      `IDX_LINE_EN:
        rd_data = 32'(s.line_en[sel_port]);
      `IDX_DONE_EN:
        rd_data = 32'(s.done_en[sel_port]);
      `IDX_FRAME_EN:
        rd_data = 32'(s.frame_en[sel_port]);
      `IDX_CH0_EN:
        rd_data = 32'(s.ch0_en[sel_port] & `CH0_MASK);
      default:
        rd_hit = 1'b0;
    endcase
  end

  // next-state logic for flags, enables, speed and the bus answer
  always_comb
  begin
    // everything holds unless a rule below changes it
    next_s = s;
    // a write lands at the edge where the answer stands
    wr_take = (s.apb == APB_DONE) && psel && penable && pwrite;
    wr_here = 1'b0;
    clr = `BYTE_ZERO;
    line_set = `BYTE_ZERO;
    done_set = `BYTE_ZERO;
    frame_set = `BYTE_ZERO;
    ch0_set = `BYTE_ZERO;
    sof_set = 1'b0;
    wrap = 1'b0;

    for (int p = 0; p < `NUM_PORTS; p++)
    begin
      // decode for the port copy handled in this pass
      wr_here = wr_take && (sel_port == p[0]);

      // line events
      line_set = `BYTE_ZERO;
      line_set[`LN_CONNECT] = conn_pulse[p]; // RQ2
      line_set[`LN_DISCON] = discon_pulse[p]; // RQ3
      line_set[`LN_WAKE] = remote_wakeup_evt[p]; // RQ4
      line_set[`LN_CHIRP_OK] = chirp_good_evt[p]; // RQ5
      line_set[`LN_CHIRP_NG] = chirp_bad_evt[p]; // RQ7
      clr = `BYTE_ZERO;
      if (wr_here && lidx == `IDX_LINE && host_ok(p[0], s.role)) // RQ8
        clr = pwdata[7:0]; // RQ1
      next_s.line[p] = `LINE_W'(w1c(8'(s.line[p]), line_set, clr)); // RQ24

      // state-management completions
      done_set = `BYTE_ZERO;
      done_set[`DN_DISABLED] = disabled_done_evt[p]; // RQ12
      done_set[`DN_RESUME] = resume_done_evt[p]; // RQ13
      done_set[`DN_SUSPEND] = suspend_done_evt[p]; // RQ14
      done_set[`DN_BUS_RESET] = bus_reset_done_evt[p]; // RQ15
      clr = `BYTE_ZERO;
      if (wr_here && lidx == `IDX_DONE && host_ok(p[0], s.role)) // RQ8
        clr = pwdata[7:0]; // RQ1
      next_s.done[p] = `DONE_W'(w1c(8'(s.done[p]), done_set, clr)); // RQ24

      // frame events: wrap on the falling edge of the high count bit
      next_s.fhi_prev[p] = frame_count_high[p][`FRAME_HI_MSB];
      wrap = s.fhi_prev[p] & ~frame_count_high[p][`FRAME_HI_MSB]; // RQ17
      sof_set = sof_hit(s.speed[p], sof_evt[p], keepalive_evt[p], microframe[p]); // RQ18
      frame_set = `BYTE_ZERO;
      frame_set[`FR_FAULT] = port_fault_evt[p]; // RQ16
      frame_set[`FR_WRAP] = wrap; // RQ17
      frame_set[`FR_SOF] = sof_set; // RQ18
      clr = `BYTE_ZERO;
      if (wr_here && lidx == `IDX_FRAME)
        clr = pwdata[7:0]; // RQ1
      next_s.frame[p] = `FRAME_W'(w1c(8'(s.frame[p]), frame_set, clr)); // RQ24

      // control channel events, reserved bits held at zero
      ch0_set = `BYTE_ZERO;
      ch0_set[`C0_SIZE_DONE] = transfer_size_done_evt[p]; // RQ21
      ch0_set[`C0_COUNT_DONE] = transaction_count_done_evt[p];
      ch0_set[`C0_TRAN_ERR] = transaction_error_evt[p]; // RQ22
      ch0_set[`C0_COND_CHG] = condition_changed_evt[p];
      ch0_set[`C0_ASSIST_DONE] = control_assist_done_evt[p];
      ch0_set[`C0_ASSIST_STOP] = control_assist_stop_evt[p];
      clr = `BYTE_ZERO;
      if (wr_here && lidx == `IDX_CH0)
        clr = pwdata[7:0]; // RQ1
      next_s.ch0[p] = w1c(s.ch0[p], ch0_set, clr) & `CH0_MASK; // RQ23

      // enables are plain read/write
      if (wr_here && lidx == `IDX_LINE_EN)
        next_s.line_en[p] = pwdata[`LINE_W-1:0];
      if (wr_here && lidx == `IDX_DONE_EN)
        next_s.done_en[p] = pwdata[`DONE_W-1:0];
      if (wr_here && lidx == `IDX_FRAME_EN)
        next_s.frame_en[p] = pwdata[`FRAME_W-1:0];
      if (wr_here && lidx == `IDX_CH0_EN)
        next_s.ch0_en[p] = pwdata[`CH0_W-1:0] & `CH0_MASK; // RQ23

      // link speed: a good chirp forces high speed over a write
      if (wr_here && lidx == `IDX_SPEED)
        next_s.speed[p] = pwdata[`SPEED_W-1:0];
      if (chirp_good_evt[p])
        next_s.speed[p] = `SPEED_HS; // RQ5

      // role select exists only on port 0
      if (wr_here && p == 0 && lidx == `IDX_ROLE)
        next_s.role = pwdata[0];
    end

    // interrupt output, low while anything enabled is pending
    next_s.irq_n = ~|port_pend; // RQ9

    // apb slave: one wait state, answer registered
    case (s.apb)
      APB_IDLE:
      begin
        // idle: answer one cycle after the access phase opens
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;
        if (psel && penable)
        begin
          next_s.apb = APB_DONE;
          next_s.pready = 1'b1;
          next_s.pslverr = ~rd_hit;
          next_s.prdata = (pwrite || !rd_hit) ? `WORD_ZERO : rd_data;
        end
      end
      APB_DONE:
      begin
        // answer stands one cycle, then back to idle
        next_s.apb = APB_IDLE;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;
      end
      default:
      begin
        next_s.apb = APB_IDLE;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;
      end
    endcase
  end

  // single state register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // reset values: interrupt high, device role, full speed
      s <= '0;
      s.irq_n <= 1'b1;
      s.role <= `ROLE_RST;
      s.speed <= {`NUM_PORTS{`SPEED_RST}};
    end
    else if (ce)
      s <= next_s;
  end

  // outputs straight from the state register
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign cpu_irq_n = s.irq_n;
  assign link_speed = s.speed;
  assign port_role_select = s.role;

endmodule
`default_nettype wire

//--- usb_hpis_cfg.svh
// How it works
// RQ1 - writing 1 clears a status flag
// RQ2 - cable attach sets connect flag bit 4
// RQ3 - cable removal sets disconnect flag bit 3
// RQ4 - remote wakeup sets line bit 2
// RQ5 - good chirp sets bit 1, speed forced HS
// RQ6 - firmware clears chirp good on disconnect
// RQ7 - bad chirp sets line bit 0
// RQ8 - line and done bits need host role
// RQ9 - enabled pending flags pull interrupt low
// RQ10 - leaving host: clear flags, then disable
// RQ11 - entering host: clear flags, then enable
// RQ12 - disable request completion sets done bit 3
// RQ13 - resume completion sets done bit 2
// RQ14 - suspend completion sets done bit 1
// RQ15 - bus reset completion sets done bit 0
// RQ16 - port fault sets frame bit 2
// RQ17 - frame counter bit 2 fall sets wrap
// RQ18 - start-of-frame flag follows link speed
// RQ19 - summary bit per channel with enabled flag
// RQ20 - second port copy sits 200h higher
// RQ21 - transfer completion sets size-done flag
// RQ22 - retry error sets transaction error flag
// RQ23 - writing 0 keeps; reserved bits read 0
// RQ24 - set beats clear in same cycle
`ifndef USB_HPIS_CFG_SVH
`define USB_HPIS_CFG_SVH

`define NUM_PORTS 2
`define NUM_CHAN 5
`define ADDR_W 16
`define IDX_W 12
`define IDX_LO 2
`define IDX_HI 13
`define PORT_BIT 9
`define PORT_STRIDE 12'h200
// register indexes, byte address is four times the index
`define IDX_SPEED 12'h13D
`define IDX_ROLE 12'h13E
`define IDX_LINE 12'h140
`define IDX_DONE 12'h141
`define IDX_FRAME 12'h143
`define IDX_CHSUM 12'h144
`define IDX_CH0 12'h145
`define IDX_LINE_EN 12'h150
`define IDX_DONE_EN 12'h151
`define IDX_FRAME_EN 12'h153
`define IDX_CH0_EN 12'h155
// field widths and positions
`define LINE_W 5
`define DONE_W 4
`define FRAME_W 3
`define CH0_W 8
`define SPEED_W 2
`define UFRAME_W 3
`define LN_CONNECT 4
`define LN_DISCON 3
`define LN_WAKE 2
`define LN_CHIRP_OK 1
`define LN_CHIRP_NG 0
`define DN_DISABLED 3
`define DN_RESUME 2
`define DN_SUSPEND 1
`define DN_BUS_RESET 0
`define FR_FAULT 2
`define FR_WRAP 1
`define FR_SOF 0
`define C0_SIZE_DONE 7
`define C0_COUNT_DONE 6
`define C0_TRAN_ERR 5
`define C0_COND_CHG 4
`define C0_ASSIST_DONE 1
`define C0_ASSIST_STOP 0
`define CH0_MASK 8'hF3
`define FRAME_HI_MSB 2
// link speed codes and reset values
`define SPEED_HS 2'h0
`define SPEED_FS 2'h1
`define SPEED_LS 2'h2
`define SPEED_RST 2'h1
`define UFRAME_ZERO 3'h0
`define ROLE_RST 1'h0
`define ROLE_HOST 1'h1
`define BYTE_ZERO 8'h00
`define WORD_ZERO 32'h0000_0000

`endif

//--- usb_hpis_pkg.sv
`default_nettype none
`include "usb_hpis_cfg.svh"
package usb_hpis_pkg;

  typedef enum logic {APB_IDLE, APB_DONE} apb_state_t;

  typedef struct packed {
    apb_state_t apb;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq_n;
    logic role;
    logic [`NUM_PORTS-1:0][`LINE_W-1:0] line;
    logic [`NUM_PORTS-1:0][`DONE_W-1:0] done;
    logic [`NUM_PORTS-1:0][`FRAME_W-1:0] frame;
    logic [`NUM_PORTS-1:0][`CH0_W-1:0] ch0;
    logic [`NUM_PORTS-1:0][`LINE_W-1:0] line_en;
    logic [`NUM_PORTS-1:0][`DONE_W-1:0] done_en;
    logic [`NUM_PORTS-1:0][`FRAME_W-1:0] frame_en;
    logic [`NUM_PORTS-1:0][`CH0_W-1:0] ch0_en;
    logic [`NUM_PORTS-1:0][`SPEED_W-1:0] speed;
    logic [`NUM_PORTS-1:0] fhi_prev;
  } status_state_t;

  typedef struct packed {
    logic [2:0] pin;
    logic rise;
    logic fall;
  } line_detect_t;

  typedef struct packed {
    logic [`NUM_CHAN-1:0] summary;
  } summary_t;

endpackage
`default_nettype wire

//--- line_detect.sv
`timescale 1ns/1ps
`default_nettype none
`include "usb_hpis_cfg.svh"
module line_detect
  import usb_hpis_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic attached,
  output logic attach_pulse,
  output logic detach_pulse
);

  line_detect_t s;
  line_detect_t next_s;

  // two-flop synchroniser, then edge detect on the settled copy
  always_comb
  begin
    next_s = s;
    next_s.pin = {s.pin[1], s.pin[0], attached};
    next_s.rise = s.pin[1] & ~s.pin[2]; // RQ2
    next_s.fall = ~s.pin[1] & s.pin[2]; // RQ3
  end

  // state register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else if (ce)
      s <= next_s;
  end

  assign attach_pulse = s.rise;
  assign detach_pulse = s.fall;

endmodule
`default_nettype wire

//--- channel_summary.sv
`timescale 1ns/1ps
`default_nettype none
`include "usb_hpis_cfg.svh"
module channel_summary
  import usb_hpis_pkg::*;
#(
  parameter int CHANNELS = `NUM_CHAN
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [CHANNELS-1:0][7:0] chan_status,
  input wire logic [CHANNELS-1:0][7:0] chan_enable,
  output logic [CHANNELS-1:0] summary
);

  summary_t s;
  summary_t next_s;
  logic [CHANNELS-1:0] hit;

  // true when any enabled flag is pending
  function automatic logic any_enabled(input logic [7:0] st, input logic [7:0] en);
    return |(st & en);
  endfunction

  // one summary bit per channel
  genvar c;
  generate
    for (c = 0; c < CHANNELS; c++)
    begin : g_chan
      assign hit[c] = any_enabled(chan_status[c], chan_enable[c]); // RQ19
    end
  endgenerate

  // registered copy of the summary
  always_comb
  begin
    next_s = s;
    next_s.summary = hit;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else if (ce)
      s <= next_s;
  end

  assign summary = s.summary;

endmodule
`default_nettype wire

//--- usb_hpis_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "usb_hpis_cfg.svh"
module usb_hpis_assertions
  import usb_hpis_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [`NUM_PORTS-1:0] chirp_good_evt,
  input wire logic [`NUM_PORTS-1:0][`SPEED_W-1:0] link_speed,
  input wire logic port_role_select
);
  // register index, and the same with the port bit masked off
  logic [11:0] idx;
  logic [11:0] loc;
  assign idx = paddr[13:2];
  assign loc = idx & 12'hDFF;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // request taken while idle, then a one-cycle answer
  sequence taken_s;
    ce && psel && penable && !pready;
  endsequence
  sequence answer_s;
    pready ##1 !pready;
  endsequence
  answer_time_a: assert property (taken_s ##1 ce |-> answer_s)
    else $error("apb answer late or too long");
  err_with_answer_a: assert property (pslverr |-> pready)
    else $error("error without answer");
  unmapped_err_a: assert property (pready && loc == 12'h142 |-> pslverr && prdata == `WORD_ZERO)
    else $error("unmapped index not refused");
  line_reserved_a: assert property (pready && !pwrite && loc == `IDX_LINE |-> prdata[31:`LINE_W] == '0)
    else $error("line status reserved bits set");
  role_gate_a: assert property (pready && !pwrite && idx == `IDX_DONE && !port_role_select |-> prdata == '0)
    else $error("done flags readable outside host role");
  summary_bits_a: assert property (pready && loc == `IDX_CHSUM |-> !pslverr && prdata[31:`NUM_CHAN] == '0)
    else $error("summary read malformed");
  chirp_speed_a: assert property (ce && chirp_good_evt[0] |=> link_speed[0] == `SPEED_HS)
    else $error("good chirp did not force high speed");
  role_write_a: assert property (pready && pwrite && idx == `IDX_ROLE |=> port_role_select == $past(pwdata[0]))
    else $error("role write lost");
endmodule
bind usb_host_port_interrupt_status usb_hpis_assertions chk_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .chirp_good_evt, .link_speed, .port_role_select);
`default_nettype wire

//--- usb_device_model.sv
`timescale 1ns/1ps
`default_nettype none
module usb_device_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] cable,
  input wire logic go,
  input wire logic [3:0] code,
  input wire logic [1:0] port_sel,
  output logic [1:0] line_attached,
  output logic [15:0][1:0] evt
);
  // cable presence is a plain level per port
  assign line_attached = cable;
  // each request gives one single-cycle pulse on the chosen line and ports
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      evt <= '0;
    else
    begin
      evt <= '0;
      if (go)
        evt[code] <= port_sel;
    end
  end
endmodule
`default_nettype wire

//--- usb_host_port_interrupt_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "usb_hpis_cfg.svh"
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin miscompares++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, x); end end
module usb_host_port_interrupt_status_bench
  import usb_hpis_pkg::*;
;
  logic pclk, presetn, ce, psel, penable, pwrite, go, e;
  logic [15:0] paddr;
  logic [31:0] pwdata, rv;
  logic [1:0] cable, pp;
  logic [3:0] cd;
  logic [1:0][2:0] microframe;
  logic [1:0][7:0] frame_count_high;
  logic [1:0][4:0][7:0] chan_status, chan_enable;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, cpu_irq_n, port_role_select;
  wire logic [1:0][1:0] link_speed;
  wire logic [1:0] line_attached;
  wire logic [15:0][1:0] evt;
  int checks, miscompares;
  // event code order: register index and the flag it must set
  logic [19:0] rows [16] = '{{`IDX_LINE, 8'h04}, {`IDX_LINE, 8'h02}, {`IDX_LINE, 8'h01}, {`IDX_DONE, 8'h08},
    {`IDX_DONE, 8'h04}, {`IDX_DONE, 8'h02}, {`IDX_DONE, 8'h01}, {`IDX_FRAME, 8'h04}, {`IDX_FRAME, 8'h01},
    {`IDX_FRAME, 8'h00}, {`IDX_CH0, 8'h80}, {`IDX_CH0, 8'h40}, {`IDX_CH0, 8'h20}, {`IDX_CH0, 8'h10},
    {`IDX_CH0, 8'h02}, {`IDX_CH0, 8'h01}};

  usb_device_model dev_u (.pclk, .presetn, .cable, .go, .code(cd), .port_sel(pp), .line_attached, .evt);

  usb_host_port_interrupt_status dut_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .line_attached, .remote_wakeup_evt(evt[0]), .chirp_good_evt(evt[1]),
    .chirp_bad_evt(evt[2]), .disabled_done_evt(evt[3]), .resume_done_evt(evt[4]), .suspend_done_evt(evt[5]),
    .bus_reset_done_evt(evt[6]), .port_fault_evt(evt[7]), .sof_evt(evt[8]), .keepalive_evt(evt[9]),
    .transfer_size_done_evt(evt[10]), .transaction_count_done_evt(evt[11]), .transaction_error_evt(evt[12]),
    .condition_changed_evt(evt[13]), .control_assist_done_evt(evt[14]), .control_assist_stop_evt(evt[15]),
    .microframe, .frame_count_high, .chan_status, .chan_enable, .cpu_irq_n, .link_speed, .port_role_select);

  // clock
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // print counts and verdict, then stop
  task results;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one apb transfer; read data and error land in rv and e
  task automatic apb(input logic w, input logic [11:0] i, input int p, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00} | (p != 0 ? 16'h0800 : 16'h0000);
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      miscompares++;
      results();
    end
    rv = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask

  // ask the far side for one event pulse
  task automatic fire(input int c, input logic [1:0] ps);
    cd <= c[3:0];
    pp <= ps;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  // main sequence
  initial
  begin
    checks = 0;
    miscompares = 0;
    {presetn, psel, penable, pwrite, go, cd, pp, cable, paddr, pwdata} = '0;
    {microframe, frame_count_high, chan_status, chan_enable} = '0;
    ce = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `IDX_SPEED, 0, 0);
    `CHK(rv, 32'h1)
    apb(0, `IDX_ROLE, 1, 0);
    `CHK(rv, 32'h1)
    apb(0, `IDX_ROLE, 0, 0);
    `CHK(rv, 32'h0)
    `CHK(cpu_irq_n, 1'b1)
    apb(0, 12'h142, 0, 0);
    `CHK({e, rv}, 33'h1_0000_0000)
    // port 0 flags hidden and kept until host role
    fire(0, 2'b01);
    fire(4, 2'b01);
    apb(0, `IDX_LINE, 0, 0);
    `CHK(rv, 32'h0)
    apb(0, `IDX_DONE, 0, 0);
    `CHK(rv, 32'h0)
    apb(1, `IDX_LINE, 0, 32'hFF);
    apb(1, `IDX_ROLE, 0, 32'h1);
    `CHK(port_role_select, 1'b1)
    apb(0, `IDX_LINE, 0, 0);
    `CHK(rv, 32'h4)
    apb(0, `IDX_DONE, 0, 0);
    `CHK(rv, 32'h4)
    apb(1, `IDX_LINE, 0, 32'hFF);
    apb(1, `IDX_DONE, 0, 32'hFF);
    // every event on both ports: set (keepalive sets nothing at high speed), keep under zero write, clear by one
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 16; i++)
      begin
        fire(i, p != 0 ? 2'b10 : 2'b01);
        apb(0, rows[i][19:8], p, 0);
        `CHK(rv, {24'h0, rows[i][7:0]})
        apb(1, rows[i][19:8], p, 0);
        apb(0, rows[i][19:8], p, 0);
        `CHK(rv, {24'h0, rows[i][7:0]})
        apb(1, rows[i][19:8], p, 32'hFF);
        apb(0, rows[i][19:8], p, 0);
        `CHK(rv, 32'h0)
        `CHK(cpu_irq_n, 1'b1)
      end
    `CHK(link_speed, 4'h0)
    // cable attach then removal on port 1
    cable[1] <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(0, `IDX_LINE, 1, 0);
    `CHK(rv, 32'h10)
    apb(1, `IDX_LINE, 1, 32'hFF);
    cable[1] <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(0, `IDX_LINE, 1, 0);
    `CHK(rv, 32'h8)
    apb(1, `IDX_LINE, 1, 32'hFF);
    // frame counter: rise ignored, fall of bit 2 flags wrap
    frame_count_high[0] <= 8'h04;
    repeat (3) @(posedge pclk);
    apb(0, `IDX_FRAME, 0, 0);
    `CHK(rv, 32'h0)
    frame_count_high[0] <= 8'h03;
    repeat (3) @(posedge pclk);
    apb(0, `IDX_FRAME, 0, 0);
    `CHK(rv, 32'h2)
    apb(1, `IDX_FRAME, 0, 32'hFF);
    // start of frame: not on microframe 3 at high speed, keepalive only at low speed
    microframe[0] <= 3'h3;
    fire(8, 2'b01);
    apb(0, `IDX_FRAME, 0, 0);
    `CHK(rv, 32'h0)
    apb(1, `IDX_SPEED, 1, {30'h0, `SPEED_LS});
    fire(8, 2'b10);
    apb(0, `IDX_FRAME, 1, 0);
    `CHK(rv, 32'h0)
    fire(9, 2'b10);
    apb(0, `IDX_FRAME, 1, 0);
    `CHK(rv, 32'h1)
    apb(1, `IDX_FRAME, 1, 32'hFF);
    // interrupt follows only enabled flags
    apb(1, `IDX_DONE_EN, 1, 32'h4);
    fire(5, 2'b10);
    `CHK(cpu_irq_n, 1'b1)
    fire(4, 2'b10);
    `CHK(cpu_irq_n, 1'b0)
    // clear of both flags meets a new resume event at the same edge
    fork
      apb(1, `IDX_DONE, 1, 32'h6);
      begin
        @(posedge pclk iff (psel && !penable));
        cd <= 4'h4;
        pp <= 2'b10;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
      end
    join
    apb(0, `IDX_DONE, 1, 0);
    `CHK(rv, 32'h4)
    apb(1, `IDX_DONE, 1, 32'h4);
    repeat (2) @(posedge pclk);
    `CHK(cpu_irq_n, 1'b1)
    // channel summary needs flag and enable on the same bit
    chan_status[0][2] <= 8'h20;
    chan_enable[0][2] <= 8'h10;
    repeat (3) @(posedge pclk);
    apb(0, `IDX_CHSUM, 0, 0);
    `CHK(rv, 32'h0)
    chan_enable[0][2] <= 8'h30;
    repeat (3) @(posedge pclk);
    apb(0, `IDX_CHSUM, 0, 0);
    `CHK(rv, 32'h4)
    `CHK(cpu_irq_n, 1'b0)
    // leaving host role: clear flags, drop enables, then the role
    apb(1, `IDX_LINE, 0, 32'hFF);
    apb(1, `IDX_LINE_EN, 0, 32'h0);
    apb(1, `IDX_ROLE, 0, 32'h0);
    `CHK(port_role_select, 1'b0)
    // reset in mid-run brings outputs back to their reset values
    chan_status[0][2] <= 8'h00;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK({link_speed, cpu_irq_n, pready}, 6'h16)
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `IDX_CHSUM, 0, 0);
    `CHK(rv, 32'h0)
    `CHK(cpu_irq_n, 1'b1)
    results();
  end
endmodule
`default_nettype wire
